// *** logic/count_source_prescaler.sv ***
`default_nettype none
module count_source_prescaler
  import vfd_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic src_sel,
  output logic tick
);

  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic tick_reg;
  logic src_sel_reg;
  wire [6:0] div_limit = src_sel ? SRC_DIV_FAST : SRC_DIV_SLOW;
  wire wrap = (div_reg == div_limit - 7'h01);

  // Divider restarts when stopped or when the source selection changes.
  assign div_next = (!enable || src_sel != src_sel_reg || wrap) ? 7'h00 : div_reg + 7'h01;
  assign tick = tick_reg;

  // One tick per count-source period.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_reg <= 7'h00;
      tick_reg <= 1'b0;
      src_sel_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick_reg <= enable && src_sel == src_sel_reg && wrap; // RL8
      src_sel_reg <= src_sel;
    end
  end

  slow_period_a: assert property (@(posedge core_clk) disable iff (!arst_n || src_sel) // RL8
    tick |=> (!tick)[*8] ##1 (!tick)[*7] ##1 (tick || !enable || src_sel))
    else $error("slow count source period is not sixteen clocks");

endmodule
`default_nettype wire

// *** logic/vfd_timing.sv ***
`default_nettype none
// What this block does
// RL1: Software writes 1 for digit lines driven high per timing, 0 for others.
// RL2: Intervals come from mode register source bit plus three time-set registers.
// RL3: Display period is display setting plus one, times count-source period.
// RL4: Reading the display time-set register returns the live period counter.
// RL5: Leading blank period equals blank setting times count-source period.
// RL6: Dim cut-off period equals cut-off setting times count-source period.
// RL7: Cut-off applies only to gradation-mode ports whose control bit is 1.
// RL8: Source bit 0 gives one count per sixteen oscillator clocks.
// RL9: Last timing fetched from port base, first from base plus count minus one.
// RL10: Gradation control bit sits 0x50 below its data; 1 means dark.
// RL11: Software loads pointer reload with digit count minus one; reads give pointer.
// RL12: Blank first, then drive data; dark pins drop after the cut-off elapses.
module vfd_timing
  import vfd_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [7:0] port2_out,
  output logic [7:0] port0_out,
  output logic [7:0] port1_out,
  output logic [7:0] port3_out,
  output logic [7:0] port8_out
);

  // ******************************************************************
  // Storage.
  // ******************************************************************
  logic [7:0] mode_reg;
  logic [7:0] disp_set_reg;
  logic [7:0] blank_set_reg;
  logic [7:0] cut_set_reg;
  logic [7:0] reload_reg;
  logic [7:0] grad_en_reg;
  logic [7:0] ram_reg [RAM_WORDS];
  logic [7:0] dcnt_reg;
  logic [7:0] el_reg;
  logic [3:0] ptr_reg;
  logic [7:0] seg_reg [NUM_PORTS];
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic tick;

  // Relative RAM index of a port's data or gradation byte for a timing.
  function automatic logic [7:0] ram_idx(input int port, input logic [3:0] ptr,
                                         input logic grad);
    logic [7:0] base;
    base = 8'(port * PORT_SPAN) + {4'h0, ptr};
    return grad ? base : base + GRAD_GAP;
  endfunction

  // ******************************************************************
  // Bus decode.
  // ******************************************************************
  wire [9:0] widx = avs_address[11:2];
  wire req = avs_read || avs_write;
  wire accept_wr = avs_write && !wait_reg && avs_byteenable[0];
  wire in_ram = widx >= RAM_FIRST_IDX && widx <= RAM_LAST_IDX;
  wire [7:0] ram_i = 8'(widx - RAM_FIRST_IDX);
  wire [7:0] wbyte = avs_writedata[7:0];
  wire wr_mode = accept_wr && widx == MODE_IDX;
  wire start_w = wr_mode && wbyte[MODE_RUN_BIT] && !mode_reg[MODE_RUN_BIT];
  wire active_w = mode_reg[MODE_AUTO_BIT] && mode_reg[MODE_RUN_BIT];
  wire [7:0] rbyte =
    (widx == MODE_IDX) ? mode_reg :
    (widx == DISP_IDX) ? dcnt_reg : // RL4
    (widx == BLANK_IDX) ? blank_set_reg :
    (widx == CUTOFF_IDX) ? cut_set_reg :
    (widx == PTR_IDX) ? ({4'h0, ptr_reg} & PTR_READ_MASK) :
    (widx == GRAD_EN_IDX) ? grad_en_reg :
    in_ram ? ram_reg[ram_i] : 8'h00;

  // ******************************************************************
  // Timing engine decode.
  // ******************************************************************
  wire timing_end = tick && dcnt_reg == 8'h00; // RL3
  wire shown_w = active_w && el_reg >= blank_set_reg; // RL5 RL12
  wire cut_w = el_reg >= cut_set_reg; // RL6
  wire [3:0] ptr_next = (ptr_reg == 4'h0) ? reload_reg[3:0] : ptr_reg - 4'h1; // RL9
  logic [7:0] seg_next [NUM_PORTS];
  logic [7:0] kill_w [NUM_PORTS];

  for (genvar k = 0; k < NUM_PORTS; k++)
  begin : g_port
    // Dark pins of gradation ports drop once the cut-off has elapsed.
    assign kill_w[k] = (grad_en_reg[k] && cut_w) ?
                       ram_reg[ram_idx(k, ptr_reg, 1'b1)] : 8'h00; // RL7 RL10
    assign seg_next[k] = shown_w ? (ram_reg[ram_idx(k, ptr_reg, 1'b0)] & ~kill_w[k]) : 8'h00;
  end

  assign port2_out = seg_reg[0];
  assign port0_out = seg_reg[1];
  assign port1_out = seg_reg[2];
  assign port3_out = seg_reg[3];
  assign port8_out = seg_reg[4];
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

  count_source_prescaler u_prescaler (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .enable(active_w),
    .src_sel(mode_reg[MODE_SRC_BIT]), // RL2
    .tick(tick)
  );

  // Bus handshake: one wait cycle, then the access is taken.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wait_reg <= !(req && wait_reg);
      rdata_reg <= (req && wait_reg) ? {24'h00_0000, rbyte} : rdata_reg;
    end
  end

  // Control registers written by software.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= REG_RESET;
      disp_set_reg <= REG_RESET;
      blank_set_reg <= REG_RESET;
      cut_set_reg <= REG_RESET;
      reload_reg <= REG_RESET;
      grad_en_reg <= REG_RESET;
    end
    else if (accept_wr)
    begin
      mode_reg <= (widx == MODE_IDX) ? wbyte : mode_reg;
      disp_set_reg <= (widx == DISP_IDX) ? wbyte : disp_set_reg; // RL2
      blank_set_reg <= (widx == BLANK_IDX) ? wbyte : blank_set_reg;
      cut_set_reg <= (widx == CUTOFF_IDX) ? wbyte : cut_set_reg;
      reload_reg <= (widx == PTR_IDX) ? wbyte : reload_reg;
      grad_en_reg <= (widx == GRAD_EN_IDX) ? wbyte : grad_en_reg;
    end
  end

  // Display and gradation RAM.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < RAM_WORDS; i++)
      begin
        ram_reg[i] <= 8'h00;
      end
    end
    else if (accept_wr && in_ram)
    begin
      ram_reg[ram_i] <= wbyte;
    end
  end

  // Per-timing counters and the data pointer.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dcnt_reg <= 8'h00;
      el_reg <= 8'h00;
      ptr_reg <= 4'h0;
    end
    else if (start_w || !active_w)
    begin
      dcnt_reg <= disp_set_reg;
      el_reg <= 8'h00;
      ptr_reg <= reload_reg[3:0]; // RL9
    end
    else if (timing_end)
    begin
      dcnt_reg <= disp_set_reg; // RL3
      el_reg <= 8'h00;
      ptr_reg <= ptr_next;
    end
    else if (tick)
    begin
      dcnt_reg <= dcnt_reg - 8'h01;
      el_reg <= (el_reg == 8'hFF) ? el_reg : el_reg + 8'h01;
    end
  end

  // Port drivers.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int k = 0; k < NUM_PORTS; k++)
      begin
        seg_reg[k] <= 8'h00;
      end
    end
    else
    begin
      seg_reg <= seg_next; // RL12
    end
  end

  // ******************************************************************
  // Checks.
  // ******************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence timing_over;
    timing_end && active_w && !start_w;
  endsequence
  sequence counting_step;
    tick && dcnt_reg != 8'h00 && active_w && !start_w;
  endsequence

  disp_reload_a: assert property (timing_over |=> dcnt_reg == $past(disp_set_reg) // RL3
    && el_reg == 8'h00)
    else $error("display counter not reloaded at end of timing");
  disp_step_a: assert property (counting_step |=> dcnt_reg == $past(dcnt_reg) - 8'h01) // RL3
    else $error("display counter did not step down on a count");
  disp_read_a: assert property (avs_read && wait_reg && widx == DISP_IDX // RL4
    |=> !avs_waitrequest && avs_readdata[7:0] == $past(dcnt_reg))
    else $error("display register read does not return the counter");
  blank_hold_a: assert property ((seg_reg[0] | seg_reg[1] | seg_reg[2] | seg_reg[3] // RL5
    | seg_reg[4]) != 8'h00 |-> $past(el_reg) >= $past(blank_set_reg))
    else $error("segment driven during leading blank");
  dark_cut_a: assert property (active_w && grad_en_reg[0] && cut_w // RL6
    |=> (seg_reg[0] & $past(ram_reg[ram_idx(0, ptr_reg, 1'b1)])) == 8'h00)
    else $error("dark pin still driven after cut-off");
  bright_pass_a: assert property (shown_w && !grad_en_reg[2] // RL7
    |=> seg_reg[2] == $past(ram_reg[8'(2 * PORT_SPAN) + GRAD_GAP + {4'h0, ptr_reg}]))
    else $error("ordinary port data not taken from display area");
  ptr_wrap_a: assert property ((timing_over and (ptr_reg == 4'h0)) // RL9
    |=> ptr_reg == $past(reload_reg[3:0]))
    else $error("pointer did not reload after last timing");
  ptr_down_a: assert property ((timing_over and (ptr_reg != 4'h0)) // RL9
    |=> ptr_reg == $past(ptr_reg) - 4'h1)
    else $error("pointer did not step to next timing");
  idle_dark_a: assert property (!active_w ##1 !active_w // RL12
    |-> seg_reg[1] == 8'h00 && seg_reg[4] == 8'h00)
    else $error("ports driven while display stopped");
  handshake_a: assert property (req && wait_reg |=> !wait_reg ##1 wait_reg) // RL2
    else $error("bus handshake not one wait cycle");

endmodule
`default_nettype wire

// *** logic/vfd_timing_pkg.sv ***
`default_nettype none
package vfd_timing_pkg;

  // ******************************************************************
  // Register map (word indices on the Avalon-MM slave; byte address is four times the index).
  // ******************************************************************
  localparam logic [9:0] MODE_IDX = 10'h000;
  localparam logic [9:0] DISP_IDX = 10'h001;
  localparam logic [9:0] BLANK_IDX = 10'h002;
  localparam logic [9:0] CUTOFF_IDX = 10'h003;
  localparam logic [9:0] PTR_IDX = 10'h004;
  localparam logic [9:0] GRAD_EN_IDX = 10'h005;
  // Display RAM word indices; byte address is four times the index.
  localparam logic [9:0] RAM_FIRST_IDX = 10'h060;
  localparam logic [9:0] RAM_LAST_IDX = 10'h0FF;
  localparam int RAM_WORDS = 160;
  localparam int NUM_PORTS = 5;
  localparam int PORT_SPAN = 16;
  // Display data sit this far above their gradation control bytes.
  localparam logic [7:0] GRAD_GAP = 8'h50;

  // ******************************************************************
  // Mode register fields.
  // ******************************************************************
  localparam int MODE_AUTO_BIT = 0;
  localparam int MODE_RUN_BIT = 1;
  localparam int MODE_SRC_BIT = 2;
  localparam logic [7:0] PTR_READ_MASK = 8'h9F;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ******************************************************************
  // Count source: 4 us per count from a 4 MHz oscillator for source bit 0; 64 clocks per count for source bit 1.
  // ******************************************************************
  localparam int COUNT_SRC_US = 4;
  localparam int OSC_MHZ = 4;
  localparam logic [6:0] SRC_DIV_SLOW = 7'(COUNT_SRC_US * OSC_MHZ);
  localparam logic [6:0] SRC_DIV_FAST = 7'h40;

endpackage
`default_nettype wire

// *** testbench/tb_vfd_timing.sv ***
`default_nettype none
// ******************************************************************
// Self-checking bench for the display timing block.
// ******************************************************************
module tb_vfd_timing;
  import vfd_timing_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic [7:0] port2_out, port0_out, port1_out, port3_out, port8_out;
  wire logic [39:0] tube_view;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 32'h65F4446E;
  int dat[5][2];
  int grd[5][2];
  logic [7:0] rd;
  // Registers read back right after reset; the last index is unmapped.
  logic [9:0] rst_idx [5] = '{MODE_IDX, BLANK_IDX, CUTOFF_IDX, GRAD_EN_IDX, 10'h006};

  vfd_timing i_dut (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port2_out(port2_out), .port0_out(port0_out),
    .port1_out(port1_out), .port3_out(port3_out), .port8_out(port8_out));
  vfd_tube_model i_tube (.core_clk(core_clk), .arst_n(arst_n), .port2_out(port2_out),
    .port0_out(port0_out), .port1_out(port1_out), .port3_out(port3_out),
    .port8_out(port8_out), .tube_view(tube_view));

  // The clock toggles every half period of 50 ns.
  initial forever #50 core_clk = ~core_clk;

  task automatic give_verdict();
    $display("counts: %0d compared, %0d wrong", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus cycle; the request stands until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d,
    input logic [3:0] be);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    while (!done && n < 50)
    begin
      @(posedge core_clk);
      n++;
      done = (avs_waitrequest === 1'b0);
      rd = avs_readdata[7:0];
    end
    if (!done)
      bad_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  // Loads random frames, starts the scan and samples each tick in its middle.
  task automatic run_pass(input int tk, input int n, input int n1, input int n2, input int src);
    int cur;
    int off;
    int ptr;
    logic [9:0] ix;
    logic [7:0] e;
    logic [4:0] ge;
    bus(1'b1, MODE_IDX, 8'h00, 4'h1);
    for (int k = 0; k < 5; k++)
      for (int p = 0; p < 2; p++)
      begin
        dat[k][p] = (k == 2) ? (1 << p) : ($random(seed) & 255);
        grd[k][p] = $random(seed) & 255;
        ix = 10'h0B0 + 10'(16 * k + p);
        bus(1'b1, ix, 8'(dat[k][p]), 4'h1);
        bus(1'b1, ix - {2'b00, GRAD_GAP}, 8'(grd[k][p]), 4'h1);
      end
    // Slot 0 always runs gradation; slot 2 stays ordinary in the fast pass.
    ge = (5'($random(seed)) | 5'h01) & ~5'(4 * src);
    bus(1'b1, GRAD_EN_IDX, {3'h0, ge}, 4'h1);
    bus(1'b1, DISP_IDX, 8'(n), 4'h1);
    bus(1'b1, BLANK_IDX, 8'(n1), 4'h1);
    bus(1'b1, CUTOFF_IDX, 8'(n2), 4'h1);
    bus(1'b1, PTR_IDX, 8'h01, 4'h1);
    bus(1'b0, BLANK_IDX, 8'h00, 4'h0);
    check_byte("blank setting", 8'(n1), rd);
    bus(1'b1, MODE_IDX, 8'(3 + 4 * src), 4'h1);
    cur = 1;
    for (int j = 0; j < 3; j++)
      for (int q = 0; q <= n; q++)
      begin
        off = j * (n + 1) * tk + q * tk + tk / 2;
        repeat (off - cur) @(posedge core_clk);
        cur = off;
        @(negedge core_clk);
        ptr = (j % 2 == 0) ? 1 : 0;
        for (int k = 0; k < 5; k++)
        begin
          e = (q < n1) ? 8'h00 : 8'(dat[k][ptr]);
          if (ge[k] && q >= n2)
            e = e & ~8'(grd[k][ptr]);
          check_byte("port", e, tube_view[8 * k +: 8]);
        end
      end
    @(posedge core_clk);
    bus(1'b0, DISP_IDX, 8'h00, 4'h0);
    // The read lands in the last count of the third timing, so the counter is at zero.
    check_byte("live count", 8'h00, rd);
    bus(1'b1, MODE_IDX, 8'h00, 4'h1);
    repeat (4) @(posedge core_clk);
    check_byte("stopped lines", 8'h00, tube_view[15:8]);
    $display("test done: tick %0d clocks", tk);
  endtask

  // Main sequence: reset, register checks, then two scan passes.
  initial
  begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    foreach (rst_idx[i])
    begin
      bus(1'b0, rst_idx[i], 8'h00, 4'h0);
      check_byte("reset value", REG_RESET, rd);
    end
    bus(1'b1, GRAD_EN_IDX, 8'h1F, 4'h0);
    bus(1'b1, 10'h006, 8'hAA, 4'h1);
    bus(1'b0, GRAD_EN_IDX, 8'h00, 4'h0);
    check_byte("masked write", 8'h00, rd);
    bus(1'b0, 10'h006, 8'h00, 4'h0);
    check_byte("unmapped read", 8'h00, rd);
    $display("test done: registers");
    run_pass(16, 3, 1, 2, 0);
    run_pass(64, 2, 0, 1, 1);
    give_verdict();
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

// *** testbench/vfd_tube_model.sv ***
`default_nettype none
// ******************************************************************
// Fluorescent tube seen from the segment and digit lines.
// ******************************************************************
module vfd_tube_model
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] port2_out,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port3_out,
  input wire logic [7:0] port8_out,
  output logic [39:0] tube_view
);
  timeunit 1ns;
  timeprecision 1ns;
  // The glass lights one clock after the lines settle, byte k for port slot k.
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      tube_view <= 40'h0000000000;
    else
      tube_view <= {port8_out, port3_out, port1_out, port0_out, port2_out};
endmodule
`default_nettype wire
